// ==== shmc_pkg.sv ====
// shared constants and carrier types of the standby halt mode controller
package shmc_pkg;

    // halt mode selection encodings
    localparam logic [1:0] MODE_RUN        = 2'h0;
    localparam logic [1:0] MODE_STOP       = 2'h1;
    localparam logic [1:0] MODE_DEEP_IDLE  = 2'h2;
    localparam logic [1:0] MODE_PERIPH_IDLE = 2'h3;

    // reset values
    localparam logic [1:0] MODE_RESET      = MODE_RUN;
    localparam logic       RETAIN_RESET    = 1'h0;

    // level held on the clock output pin while halted in deep idle mode
    localparam logic       CLK_PIN_PARKED  = 1'h1;

    // synchroniser depth for pin inputs
    localparam int         SYNC_STAGES     = 2;

    // number of timer interrupt lines
    localparam int         TIMER_IRQS      = 4;

    // wake request sources, all active high
    typedef struct packed {
        logic                  nmi;
        logic                  ext_irq0;
        logic                  ext_irq1;
        logic [TIMER_IRQS-1:0] timer_irq;
        logic                  serial_receive_irq;
        logic                  serial_transmit_irq;
    } shmc_wake_s;

    // clock enables handed to the clock tree
    typedef struct packed {
        logic osc;
        logic watchdog;
        logic cpu;
        logic periph;
        logic core_rest;
    } shmc_clk_s;

    localparam shmc_clk_s CLK_ALL_ON = '{osc: 1'h1, watchdog: 1'h1,
        cpu: 1'h1, periph: 1'h1, core_rest: 1'h1};

endpackage

// ==== shmc_sync.sv ====
// two-flip-flop synchroniser for pin inputs
module shmc_sync #(
    parameter int   WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta     <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule

// ==== shmc_pin_ctl.sv ====
// next pin state while halted, by mode and drive retention
module shmc_pin_ctl #(
    parameter int PORT_W = 8,
    parameter int ZC_W   = 4
) (
    // halt status
    input  wire logic              halted,
    input  wire logic [1:0]        mode,
    input  wire logic              retain,
    // live values from the port logic
    input  wire logic [PORT_W-1:0] live_out,
    input  wire logic [PORT_W-1:0] live_oe,
    input  wire logic [PORT_W-1:0] live_pullup,
    input  wire logic [ZC_W-1:0]   live_zc,
    // values captured when halt was executed
    input  wire logic [PORT_W-1:0] snap_out,
    input  wire logic [PORT_W-1:0] snap_oe,
    input  wire logic [PORT_W-1:0] snap_pullup,
    input  wire logic [ZC_W-1:0]   snap_zc,
    // pin state to register
    output logic      [PORT_W-1:0] pin_out,
    output logic      [PORT_W-1:0] pin_oe,
    output logic      [PORT_W-1:0] pin_pullup,
    output logic                   pin_in_en,
    output logic      [ZC_W-1:0]   zc_bias
);

    always_comb begin
        pin_out    = live_out;
        pin_oe     = live_oe;
        pin_pullup = live_pullup;
        pin_in_en  = 1'h1;
        zc_bias    = live_zc;
        if (halted) begin
            // ports frozen at their pre-halt state
            pin_out    = snap_out;                         // [RULE_18]
            pin_oe     = snap_oe;                          // [RULE_18]
            pin_pullup = snap_pullup;                      // [RULE_12]
            zc_bias    = snap_zc;                          // [RULE_15]
            if (mode == shmc_pkg::MODE_STOP && !retain) begin // [RULE_13]
                // outputs float, input gates shut
                pin_oe    = '0;                            // [RULE_09] [RULE_14]
                pin_in_en = 1'h0;                          // [RULE_14]
            end
        end
    end

endmodule

// ==== shmc_controller.sv ====
// standby halt mode controller: halt entry, clock gating, wake, pins
//
// How it works
// RULE_01: halt instruction enters halt with selected mode
// RULE_02: two-bit mode field, reset selects run
// RULE_03: deep idle: oscillator, watchdog only; pin high
// RULE_04: deep idle wakes on request, resumes synchronously
// RULE_05: deep idle wakes only on NMI or reset
// RULE_06: peripheral idle wakes with run timing
// RULE_07: peripheral idle clocks only timers, serial
// RULE_08: peripheral idle ignores ext_irq0 and ext_irq1
// RULE_09: stop halts everything, pins high impedance
// RULE_10: stop ends only by reset
// RULE_11: outside holds NMI high during stop
// RULE_12: pulled-up pins stay pulled up in stop
// RULE_13: retention set keeps outputs and inputs in stop
// RULE_14: retention clear floats outputs, disables inputs
// RULE_15: zero-cross bias kept during stop
// RULE_16: outside holds reset until oscillator stable
// RULE_17: outside holds level ext_irq0 through response
// RULE_18: other modes keep ports as at halt
// RULE_19: run wakes on all; peripheral_idle_mode on listed sources
// RULE_20: masked wake ends halt, flag left set
// RULE_21: finish halt bus cycle before gating clocks
module shmc_controller #(
    parameter int PORT_W = 8,
    parameter int ZC_W   = 4
) (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    // core: halt and configuration
    input  wire logic                        halt_exec,
    input  wire logic                        bus_idle,
    input  wire logic                        int_enable,
    input  wire logic                        mode_wr,
    input  wire logic [1:0]                  mode_wdata,
    input  wire logic                        retain_wr,
    input  wire logic                        retain_wdata,
    // external interrupt pins
    input  wire logic                        nmi_n,
    input  wire logic                        ext_irq0,
    input  wire logic                        ext_irq1,
    // internal interrupt requests
    input  wire logic [shmc_pkg::TIMER_IRQS-1:0] timer_irq,
    input  wire logic                        serial_receive_irq,
    input  wire logic                        serial_transmit_irq,
    // live port state
    input  wire logic [PORT_W-1:0]           port_out_live,
    input  wire logic [PORT_W-1:0]           port_oe_live,
    input  wire logic [PORT_W-1:0]           pullup_live,
    input  wire logic [ZC_W-1:0]             zc_live,
    // status and wake
    output logic [1:0]                       halt_mode_selection,
    output logic                             pin_drive_retention_alt,
    output logic                             halted,
    output logic                             wake,
    output logic                             wake_service,
    // clock tree
    output shmc_pkg::shmc_clk_s              clk_en,
    output logic                             clk_pin_hold,
    // pins
    output logic [PORT_W-1:0]                pin_out,
    output logic [PORT_W-1:0]                pin_oe,
    output logic [PORT_W-1:0]                pin_pullup,
    output logic                             pin_in_en,
    output logic [ZC_W-1:0]                  zc_bias
);

    typedef enum logic [1:0] {
        SH_ACTIVE,
        SH_DRAIN,
        SH_HALT,
        SH_RESTART
    } shmc_state_e;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers and wake sources

    logic [2:0]           pins_sync;
    shmc_pkg::shmc_wake_s req;

    shmc_sync #(
        .WIDTH       (3),
        .RESET_VALUE (3'h1)
    ) u_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in ({ext_irq1, ext_irq0, nmi_n}),
        .sync_out (pins_sync)
    );

    always_comb begin
        req.nmi                 = !pins_sync[0];
        req.ext_irq0            = pins_sync[1];
        req.ext_irq1            = pins_sync[2];
        req.timer_irq           = timer_irq;
        req.serial_receive_irq  = serial_receive_irq;
        req.serial_transmit_irq = serial_transmit_irq;
    end

    // which requests may end the halt in a given mode
    function automatic logic wake_allowed(input logic [1:0] m,
                                          input shmc_pkg::shmc_wake_s r);
        logic periph;
        periph = r.nmi || (|r.timer_irq) || r.serial_receive_irq
                 || r.serial_transmit_irq;
        case (m)
            shmc_pkg::MODE_RUN:
                wake_allowed = periph || r.ext_irq0 || r.ext_irq1; // [RULE_19]
            shmc_pkg::MODE_PERIPH_IDLE:
                wake_allowed = periph;                     // [RULE_08] [RULE_19]
            shmc_pkg::MODE_DEEP_IDLE:
                wake_allowed = r.nmi;                      // [RULE_05]
            default:
                wake_allowed = 1'h0;                       // [RULE_10]
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // configuration fields

    logic [1:0] next_mode_sel;
    logic       next_retain;

    always_comb begin
        next_mode_sel = halt_mode_selection;
        next_retain   = pin_drive_retention_alt;
        if (mode_wr) begin
            next_mode_sel = mode_wdata;                    // [RULE_02]
        end
        if (retain_wr) begin
            next_retain = retain_wdata;                    // [RULE_13]
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            halt_mode_selection     <= shmc_pkg::MODE_RESET; // [RULE_02]
            pin_drive_retention_alt <= shmc_pkg::RETAIN_RESET;
        end else begin
            halt_mode_selection     <= next_mode_sel;
            pin_drive_retention_alt <= next_retain;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // halt sequencer

    shmc_state_e         state;
    shmc_state_e         next_state;
    logic [1:0]          active_mode;
    logic [1:0]          next_active_mode;
    logic                next_halted;
    logic                next_wake;
    logic                next_wake_service;
    logic                hit;
    shmc_pkg::shmc_clk_s next_clk_en;
    logic                next_clk_pin_hold;

    always_comb begin
        hit               = wake_allowed(active_mode, req);
        next_state        = state;
        next_active_mode  = active_mode;
        next_wake         = 1'h0;
        next_wake_service = 1'h0;
        case (state)
            SH_ACTIVE: begin
                if (halt_exec) begin
                    next_active_mode = halt_mode_selection; // [RULE_01]
                    next_state       = SH_DRAIN;
                end
            end
            SH_DRAIN: begin
                if (bus_idle) begin
                    next_state = SH_HALT;                  // [RULE_21]
                end
            end
            SH_HALT: begin
                if (hit) begin
                    if (active_mode == shmc_pkg::MODE_DEEP_IDLE) begin
                        next_state = SH_RESTART;           // [RULE_04]
                    end else begin
                        next_state        = SH_ACTIVE;     // [RULE_06]
                        next_wake         = 1'h1;
                        // masked request ends halt unserviced
                        next_wake_service = req.nmi || int_enable; // [RULE_20]
                    end
                end
            end
            SH_RESTART: begin
                next_state        = SH_ACTIVE;             // [RULE_04]
                next_wake         = 1'h1;
                next_wake_service = 1'h1;
            end
            default: begin
                next_state = SH_ACTIVE;
            end
        endcase

        next_halted       = (next_state == SH_HALT)
                            || (next_state == SH_RESTART);
        next_clk_en       = shmc_pkg::CLK_ALL_ON;
        next_clk_pin_hold = 1'h0;
        if (next_state == SH_HALT) begin
            next_clk_en.cpu = 1'h0;
            case (next_active_mode)
                shmc_pkg::MODE_PERIPH_IDLE: begin
                    next_clk_en.core_rest = 1'h0;          // [RULE_07]
                end
                shmc_pkg::MODE_DEEP_IDLE: begin
                    next_clk_en.core_rest = 1'h0;          // [RULE_03]
                    next_clk_en.periph    = 1'h0;
                    next_clk_pin_hold     = shmc_pkg::CLK_PIN_PARKED;
                end
                shmc_pkg::MODE_STOP: begin
                    next_clk_en = '0;                      // [RULE_09]
                end
                default: begin
                end
            endcase
        end else if (next_state == SH_RESTART) begin
            next_clk_en.cpu = 1'h0;                        // [RULE_04]
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state        <= SH_ACTIVE;
            active_mode  <= shmc_pkg::MODE_RESET;
            halted       <= 1'h0;
            wake         <= 1'h0;
            wake_service <= 1'h0;
            clk_en       <= shmc_pkg::CLK_ALL_ON;
            clk_pin_hold <= 1'h0;
        end else begin
            state        <= next_state;
            active_mode  <= next_active_mode;
            halted       <= next_halted;
            wake         <= next_wake;
            wake_service <= next_wake_service;
            clk_en       <= next_clk_en;
            clk_pin_hold <= next_clk_pin_hold;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin snapshot and pin state

    logic [PORT_W-1:0] snap_out;
    logic [PORT_W-1:0] snap_oe;
    logic [PORT_W-1:0] snap_pullup;
    logic [ZC_W-1:0]   snap_zc;
    logic [PORT_W-1:0] nx_pin_out;
    logic [PORT_W-1:0] nx_pin_oe;
    logic [PORT_W-1:0] nx_pin_pullup;
    logic              nx_pin_in_en;
    logic [ZC_W-1:0]   nx_zc_bias;
    logic              take_snap;

    assign take_snap = (state == SH_ACTIVE) && halt_exec;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            snap_out    <= '0;
            snap_oe     <= '0;
            snap_pullup <= '0;
            snap_zc     <= '0;
        end else if (take_snap) begin
            snap_out    <= port_out_live;                  // [RULE_18]
            snap_oe     <= port_oe_live;
            snap_pullup <= pullup_live;
            snap_zc     <= zc_live;
        end
    end

    shmc_pin_ctl #(
        .PORT_W (PORT_W),
        .ZC_W   (ZC_W)
    ) u_pin (
        .halted      (next_halted),
        .mode        (next_active_mode),
        .retain      (pin_drive_retention_alt),
        .live_out    (port_out_live),
        .live_oe     (port_oe_live),
        .live_pullup (pullup_live),
        .live_zc     (zc_live),
        .snap_out    (take_snap ? port_out_live : snap_out),
        .snap_oe     (take_snap ? port_oe_live : snap_oe),
        .snap_pullup (take_snap ? pullup_live : snap_pullup),
        .snap_zc     (take_snap ? zc_live : snap_zc),
        .pin_out     (nx_pin_out),
        .pin_oe      (nx_pin_oe),
        .pin_pullup  (nx_pin_pullup),
        .pin_in_en   (nx_pin_in_en),
        .zc_bias     (nx_zc_bias)
    );

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_out    <= '0;
            pin_oe     <= '0;
            pin_pullup <= '0;
            pin_in_en  <= 1'h1;
            zc_bias    <= '0;
        end else begin
            pin_out    <= nx_pin_out;
            pin_oe     <= nx_pin_oe;
            pin_pullup <= nx_pin_pullup;
            pin_in_en  <= nx_pin_in_en;
            zc_bias    <= nx_zc_bias;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions

    property p_enter;
        @(posedge clk) disable iff (!reset_n)
        state == SH_ACTIVE && halt_exec
            |=> state == SH_DRAIN && active_mode == $past(halt_mode_selection);
    endproperty
    a_enter: assert property (p_enter)                     // [RULE_01]
        else $error("halt entry did not take selected mode");

    property p_drain;
        @(posedge clk) disable iff (!reset_n)
        state == SH_DRAIN && !bus_idle |=> state == SH_DRAIN && clk_en.cpu;
    endproperty
    a_drain: assert property (p_drain)                     // [RULE_21]
        else $error("clock gated before halt bus cycle ended");

    property p_deep_clocks;
        @(posedge clk) disable iff (!reset_n)
        state == SH_HALT && active_mode == shmc_pkg::MODE_DEEP_IDLE
            |-> clk_en.osc && clk_en.watchdog && !clk_en.core_rest
                && !clk_en.periph && clk_pin_hold;
    endproperty
    a_deep_clocks: assert property (p_deep_clocks)         // [RULE_03]
        else $error("deep idle clocks wrong");

    property p_deep_resume;
        @(posedge clk) disable iff (!reset_n)
        state == SH_HALT && active_mode == shmc_pkg::MODE_DEEP_IDLE && req.nmi
            |=> state == SH_RESTART && !wake ##1 wake && clk_en.core_rest;
    endproperty
    a_deep_resume: assert property (p_deep_resume)         // [RULE_04]
        else $error("deep idle resume not one cycle after restart");

    property p_deep_only_nmi;
        @(posedge clk) disable iff (!reset_n)
        state == SH_HALT && active_mode == shmc_pkg::MODE_DEEP_IDLE && !req.nmi
            |=> state == SH_HALT;
    endproperty
    a_deep_only_nmi: assert property (p_deep_only_nmi)     // [RULE_05]
        else $error("deep idle left halt without nmi");

    property p_periph_wake;
        @(posedge clk) disable iff (!reset_n)
        state == SH_HALT && active_mode == shmc_pkg::MODE_PERIPH_IDLE
            && (|req.timer_irq) |=> wake && state == SH_ACTIVE;
    endproperty
    a_periph_wake: assert property (p_periph_wake)         // [RULE_06]
        else $error("peripheral idle wake timing wrong");

    property p_periph_clocks;
        @(posedge clk) disable iff (!reset_n)
        state == SH_HALT && active_mode == shmc_pkg::MODE_PERIPH_IDLE
            |-> clk_en.periph && !clk_en.core_rest && !clk_en.cpu;
    endproperty
    a_periph_clocks: assert property (p_periph_clocks)     // [RULE_07]
        else $error("peripheral idle clocks wrong");

    property p_periph_ext;
        @(posedge clk) disable iff (!reset_n)
        state == SH_HALT && active_mode == shmc_pkg::MODE_PERIPH_IDLE
            && !req.nmi && !(|req.timer_irq) && !req.serial_receive_irq
            && !req.serial_transmit_irq |=> state == SH_HALT;
    endproperty
    a_periph_ext: assert property (p_periph_ext)           // [RULE_08]
        else $error("external irq ended peripheral idle");

    property p_stop;
        @(posedge clk) disable iff (!reset_n)
        state == SH_HALT && active_mode == shmc_pkg::MODE_STOP
            |=> state == SH_HALT && clk_en == '0 && !wake;
    endproperty
    a_stop: assert property (p_stop)                       // [RULE_10]
        else $error("stop left without reset");

    property p_stop_float;
        @(posedge clk) disable iff (!reset_n)
        state == SH_HALT && active_mode == shmc_pkg::MODE_STOP
            && !pin_drive_retention_alt |-> pin_oe == '0 && !pin_in_en;
    endproperty
    a_stop_float: assert property (p_stop_float)           // [RULE_14]
        else $error("stop pins not floated");

    property p_masked;
        @(posedge clk) disable iff (!reset_n)
        state == SH_HALT && active_mode != shmc_pkg::MODE_DEEP_IDLE
            && hit && !int_enable && !req.nmi |=> wake && !wake_service;
    endproperty
    a_masked: assert property (p_masked)                   // [RULE_20]
        else $error("masked wake was serviced");

endmodule

// ==== shmc_core_model.sv ====
// model of the core bus cycle and the nmi pin driver outside the block
module shmc_core_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // core side
    input  wire logic       halt_exec,
    input  wire logic [1:0] lat,
    output logic            bus_idle,
    // nmi pin side
    input  wire logic       nmi_req,
    input  wire logic       in_stop,
    output logic            nmi_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt;
    // halt bus cycle ends lat cycles after the halt instruction
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) cnt <= 2'h0;
        else if (halt_exec) cnt <= lat;
        else if (cnt != 2'h0) cnt <= cnt - 2'h1;
    end
    assign bus_idle = (cnt == 2'h0) && !halt_exec;
    assign nmi_n = in_stop ? 1'h1 : !nmi_req;
endmodule

// ==== tb_top.sv ====
// self-checking bench of the standby halt mode controller
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk, reset_n, halt_exec, bus_idle, int_enable, nmi_n, ret;
    logic       mode_wr, retain_wr, retain_wdata, nmi_req, ext_irq0, ext_irq1;
    logic       serial_receive_irq, serial_transmit_irq, halted, wake;
    logic       pin_drive_retention_alt, wake_service, clk_pin_hold, pin_in_en;
    logic [1:0] mode_wdata, lat, halt_mode_selection;
    logic [3:0] timer_irq, zc_live, zc_bias, szc;
    logic [7:0] port_out_live, port_oe_live, pullup_live, so, soe, spu;
    logic [7:0] pin_out, pin_oe, pin_pullup;
    logic [8:0] src;
    int         errors, num_checks;
    shmc_pkg::shmc_clk_s clk_en;
    assign {nmi_req, ext_irq0, ext_irq1, timer_irq, serial_receive_irq,
            serial_transmit_irq} = src;

    shmc_controller #(.PORT_W(8), .ZC_W(4)) uut (
        .clk, .reset_n, .halt_exec, .bus_idle, .int_enable, .mode_wr,
        .mode_wdata, .retain_wr, .retain_wdata, .nmi_n, .ext_irq0, .ext_irq1,
        .timer_irq, .serial_receive_irq, .serial_transmit_irq, .port_out_live,
        .port_oe_live, .pullup_live, .zc_live, .halt_mode_selection,
        .pin_drive_retention_alt, .halted, .wake, .wake_service, .clk_en,
        .clk_pin_hold, .pin_out, .pin_oe, .pin_pullup, .pin_in_en, .zc_bias
    );
    shmc_core_model partner (
        .clk, .reset_n, .halt_exec, .lat, .bus_idle, .nmi_req, .nmi_n,
        .in_stop(halted && halt_mode_selection == shmc_pkg::MODE_STOP)
    );

    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic allowed(input logic [1:0] m, input int s);
        case (m)
            shmc_pkg::MODE_RUN:         return 1'h1;
            shmc_pkg::MODE_PERIPH_IDLE: return s != 7 && s != 6;
            shmc_pkg::MODE_DEEP_IDLE:   return s == 8;
            default:                    return 1'h0;
        endcase
    endfunction
    // expected {osc, watchdog, cpu, periph, core_rest} while halted
    function automatic logic [4:0] exp_clk(input logic [1:0] m);
        case (m)
            shmc_pkg::MODE_RUN:         return 5'h1B;
            shmc_pkg::MODE_PERIPH_IDLE: return 5'h1A;
            shmc_pkg::MODE_DEEP_IDLE:   return 5'h18;
            default:                    return 5'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #10;
    endtask
    // waits for wake when on_wake is set, otherwise for halted
    task automatic wait_sig(input bit on_wake, input int lim, output bit hit);
        hit = 1'b0;
        for (int i = 0; i < lim && !hit; i++) begin
            tick();
            if ((on_wake ? wake : halted) === 1'h1) hit = 1'b1;
        end
    endtask
    task automatic set_mode(input logic [1:0] m);
        mode_wr = 1'h1;
        mode_wdata = m;
        tick();
        mode_wr = 1'h0;
        tick();
        chk(halt_mode_selection, m);
    endtask
    task automatic do_halt(input logic [1:0] m);
        bit h;
        bit stop;
        stop = m == shmc_pkg::MODE_STOP;
        {port_out_live, port_oe_live, pullup_live} = 24'($urandom);
        zc_live = 4'($urandom);
        lat = 2'($urandom);
        tick();
        {so, soe, spu} = {port_out_live, port_oe_live, pullup_live};
        szc = zc_live;
        halt_exec = 1'h1;
        tick();
        halt_exec = 1'h0;
        // halted must not rise before the halt bus cycle has ended
        repeat (lat) tick();
        chk(halted, 1'h0);
        wait_sig(1'b0, 10, h);
        if (!h) begin
            errors++;
            print_verdict();
        end
        {port_out_live, port_oe_live, pullup_live} = 24'($urandom);
        zc_live = 4'($urandom);
        tick(2);
        chk(clk_en, exp_clk(m));
        if (!stop) chk(clk_pin_hold, m == shmc_pkg::MODE_DEEP_IDLE);
        if (!stop || ret) chk(pin_out, so);
        chk(pin_oe, (stop && !ret) ? 8'h0 : soe);
        chk(pin_in_en, !(stop && !ret));
        chk(pin_pullup, spu);
        chk(zc_bias, szc);
    endtask
    task automatic wake_try(input logic [1:0] m, input int s);
        bit h;
        int_enable = 1'($urandom);
        do_halt(m);
        src = 9'h0;
        // level source held until the halt is seen to end
        src[s] = 1'h1;
        wait_sig(1'b1, 10, h);
        chk(h, allowed(m, s));
        if (!h) begin
            src[8] = 1'h1;
            wait_sig(1'b1, 10, h);
            chk(h, 1'h1);
        end
        chk(wake_service, src[8] | int_enable);
        src = 9'h0;
        tick(4);
        chk(halted, 1'h0);
    endtask
    task automatic stop_try(input logic r);
        bit h;
        ret = r;
        retain_wr = 1'h1;
        retain_wdata = r;
        tick();
        retain_wr = 1'h0;
        tick();
        chk(pin_drive_retention_alt, r);
        set_mode(shmc_pkg::MODE_STOP);
        do_halt(shmc_pkg::MODE_STOP);
        src = 9'h1FF;
        wait_sig(1'b1, 10, h);
        chk(h, 1'h0);
        src = 9'h0;
        reset_n = 1'h0;
        tick(20);
        reset_n = 1'h1;
        ret = 1'h0;
        tick();
        chk(halted, 1'h0);
        chk(clk_en, shmc_pkg::CLK_ALL_ON);
        $display("test stop retention %h done", r);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [1:0] ml [3];
        ml = '{shmc_pkg::MODE_RUN, shmc_pkg::MODE_PERIPH_IDLE,
               shmc_pkg::MODE_DEEP_IDLE};
        {reset_n, halt_exec, int_enable, mode_wr, retain_wr} = 5'h0;
        {retain_wdata, mode_wdata, lat, src, ret} = 15'h0;
        {port_out_live, port_oe_live, pullup_live, zc_live} = 28'h0;
        void'($urandom(32'h32E9));
        tick(20);
        reset_n = 1'h1;
        tick();
        chk(halt_mode_selection, shmc_pkg::MODE_RESET);
        chk(pin_drive_retention_alt, shmc_pkg::RETAIN_RESET);
        chk(clk_en, shmc_pkg::CLK_ALL_ON);
        for (int i = 0; i < 3; i++) begin
            set_mode(ml[i]);
            for (int s = 0; s < 9; s++) wake_try(ml[i], s);
            $display("test mode %h done", ml[i]);
        end
        stop_try(1'h0);
        stop_try(1'h1);
        print_verdict();
    end
endmodule
